// ---- design/scs_pkg.sv ----
package scs_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [11:0] ADDR_STABILIZER_CTRL_SECOND = 12'h011e;
    localparam logic [11:0] ADDR_STABILIZER_CTRL_THIRD = 12'h011f;
    localparam logic [11:0] ADDR_CAPTURE_CTRL_MAIN = 12'h0120;
    localparam logic [11:0] ADDR_IGNORE_COUNT_CTRL = 12'h0121;
    localparam logic [11:0] ADDR_TIMESTAMP_DELAY_CTRL = 12'h0123;
    localparam logic [11:0] ADDR_CAPTURE_COUNT = 12'h012a;

    // values after reset
    localparam logic [7:0] RST_STABILIZER_CTRL_SECOND = 8'h0088;
    localparam logic [7:0] RST_STABILIZER_CTRL_THIRD = 8'h0084;
    localparam logic [7:0] RST_CAPTURE_CTRL_MAIN = 8'h0000;
    localparam logic [3:0] RST_IGNORE_COUNT = 4'h0;
    localparam logic [6:0] RST_TIMESTAMP_DELAY = 7'h40;
    localparam logic [7:0] RST_CAPTURE_COUNT = 8'h0000;

    // field positions and write masks
    localparam int STABILIZER_ENABLE_BIT = 1;
    localparam int STABILIZER_POWER_BIT = 0;
    localparam int FLAG_RESET_BIT = 6;
    localparam int TRANS_SELECT_BIT = 4;
    localparam int EDGE_SELECT_BIT = 3;
    localparam int MODE_LSB = 1;
    localparam logic [7:0] CAPTURE_CTRL_WMASK = 8'h005e;

    // capture modes
    localparam logic [1:0] MODE_DISABLED = 2'h0;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
    localparam logic [1:0] MODE_NSHOT = 2'h2;

    localparam int TIMESTAMP_DEPTH = 128;

endpackage

// ---- design/scs_delay_line.sv ----
`timescale 1ns/1ps
module scs_delay_line
    import scs_pkg::*;
#(
    parameter int DEPTH = scs_pkg::TIMESTAMP_DEPTH,
    parameter int SEL_W = 7
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic evt,
    input wire logic [SEL_W-1:0] delay,
    output logic pulse_q
);
    logic [DEPTH-2:0] shift_q;
    logic [DEPTH-2:0] shift_d;
    logic pulse_d;

    // a tap of zero passes the event on the next edge, tap n adds n cycles
    always_comb
    begin
        shift_d = {shift_q[DEPTH-3:0], evt};
        if (delay == '0)
            pulse_d = evt;
        else
            pulse_d = shift_q[delay - SEL_W'(1)]; // [R7]
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            shift_q <= '0;
            pulse_q <= 1'b0;
        end
        else
        begin
            shift_q <= shift_d;
            pulse_q <= pulse_d;
        end
    end
endmodule

// ---- design/scs_capture.sv ----
// How it works
// R1: second stabilizer register: bit 1 enables, bit 0 powers; match first register.
// R2: flag-reset bit 6 high holds setup and hold error flags cleared.
// R3: transition-select bit 4: 0 takes rising, 1 takes falling reference transitions.
// R4: mode bits [2:1]: 00 off, 01 continuous, 10 n-shot; disable before changing.
// R5: edge-select bit 3: 0 samples on rising clock edge, 1 on falling.
// R6: n-shot skips the first ignore-count transitions, 0 to 15, before using one.
// R7: timestamp is delayed by 0 to 127 sample clocks, reset value 0x40.
// R8: eight-bit wrapping count of captures, cleared while flag-reset is high.
// R9: n-shot captures exactly one transition, then waits for a mode rewrite.
`timescale 1ns/1ps
module scs_capture
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [scs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [scs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [scs_pkg::DATA_W-1:0] reg_rdata,
    input wire logic sysref_pin,
    input wire logic setup_err,
    input wire logic hold_err,
    output logic stabilizer2_enable,
    output logic stabilizer2_power,
    output logic [scs_pkg::DATA_W-1:0] stabilizer3_ctrl,
    output logic sysref_capture,
    output logic sysref_timestamp,
    output logic setup_flag,
    output logic hold_flag,
    output logic [7:0] sysref_count
);
    import scs_pkg::*;

    // pin synchronisers, one per clock edge
    logic rise_s1_q;
    logic rise_s2_q;
    logic fall_s1_q;
    logic fall_s2_q;
    logic fall_s3_q;
    logic samp;
    logic prev_q;
    logic valid_trans;

    logic [7:0] stabilizer2_q, stabilizer2_d;
    logic [7:0] stabilizer3_q, stabilizer3_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [3:0] ignore_q, ignore_d;
    logic [6:0] delay_q, delay_d;
    logic [7:0] rdata_q, rdata_d;
    logic ctrl_wr;

    logic [1:0] mode;
    logic [3:0] left_q, left_d;
    logic done_q, done_d;
    logic capture_q, capture_d;
    logic [7:0] count_q, count_d;
    logic setup_q, setup_d;
    logic hold_q, hold_d;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rise_s1_q <= 1'b0;
            rise_s2_q <= 1'b0;
        end
        else
        begin
            rise_s1_q <= sysref_pin;
            rise_s2_q <= rise_s1_q;
        end
    end

    always_ff @(negedge core_clk)
    begin
        if (rst)
        begin
            fall_s1_q <= 1'b0;
            fall_s2_q <= 1'b0;
        end
        else
        begin
            fall_s1_q <= sysref_pin;
            fall_s2_q <= fall_s1_q;
        end
    end

    // choose the sampling edge and detect the selected transition
    always_comb
    begin
        samp = ctrl_q[EDGE_SELECT_BIT] ? fall_s3_q : rise_s2_q; // [R5]
        if (ctrl_q[TRANS_SELECT_BIT])
            valid_trans = prev_q && !samp; // [R3]
        else
            valid_trans = !prev_q && samp; // [R3]
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            fall_s3_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            fall_s3_q <= fall_s2_q;
            prev_q <= samp;
        end
    end

    // register file
    always_comb
    begin
        stabilizer2_d = stabilizer2_q;
        stabilizer3_d = stabilizer3_q;
        ctrl_d = ctrl_q;
        ignore_d = ignore_q;
        delay_d = delay_q;
        ctrl_wr = reg_we && (reg_addr == ADDR_CAPTURE_CTRL_MAIN);
        if (reg_we)
        begin
            case (reg_addr)
                ADDR_STABILIZER_CTRL_SECOND: stabilizer2_d = reg_wdata; // [R1]
                ADDR_STABILIZER_CTRL_THIRD: stabilizer3_d = reg_wdata;
                ADDR_CAPTURE_CTRL_MAIN: ctrl_d = reg_wdata & CAPTURE_CTRL_WMASK;
                ADDR_IGNORE_COUNT_CTRL: ignore_d = reg_wdata[3:0];
                ADDR_TIMESTAMP_DELAY_CTRL: delay_d = reg_wdata[6:0];
                default: ;
            endcase
        end
        rdata_d = rdata_q;
        if (reg_re)
        begin
            case (reg_addr)
                ADDR_STABILIZER_CTRL_SECOND: rdata_d = stabilizer2_q;
                ADDR_STABILIZER_CTRL_THIRD: rdata_d = stabilizer3_q;
                ADDR_CAPTURE_CTRL_MAIN: rdata_d = ctrl_q;
                ADDR_IGNORE_COUNT_CTRL: rdata_d = {4'h0, ignore_q};
                ADDR_TIMESTAMP_DELAY_CTRL: rdata_d = {1'b0, delay_q};
                ADDR_CAPTURE_COUNT: rdata_d = count_q;
                default: rdata_d = 8'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stabilizer2_q <= RST_STABILIZER_CTRL_SECOND;
            stabilizer3_q <= RST_STABILIZER_CTRL_THIRD;
            ctrl_q <= RST_CAPTURE_CTRL_MAIN;
            ignore_q <= RST_IGNORE_COUNT;
            delay_q <= RST_TIMESTAMP_DELAY; // [R7]
            rdata_q <= 8'h0000;
        end
        else
        begin
            stabilizer2_q <= stabilizer2_d;
            stabilizer3_q <= stabilizer3_d;
            ctrl_q <= ctrl_d;
            ignore_q <= ignore_d;
            delay_q <= delay_d;
            rdata_q <= rdata_d;
        end
    end

    // capture sequencing
    always_comb
    begin
        mode = ctrl_q[MODE_LSB+1:MODE_LSB];
        left_d = left_q;
        done_d = done_q;
        capture_d = 1'b0;
        case (mode) // [R4]
            MODE_CONTINUOUS: capture_d = valid_trans;
            MODE_NSHOT:
            begin
                if (valid_trans && !done_q)
                begin
                    if (left_q == 4'h0)
                    begin
                        capture_d = 1'b1;
                        done_d = 1'b1; // [R9]
                    end
                    else
                        left_d = left_q - 4'h1; // [R6]
                end
            end
            default: capture_d = 1'b0;
        endcase
        // rewriting the mode rearms the ignore count and the single shot
        if (ctrl_wr)
        begin
            left_d = ignore_q; // [R6]
            done_d = 1'b0; // [R9]
        end
        if (ctrl_q[FLAG_RESET_BIT])
        begin
            count_d = 8'h0000; // [R8]
            setup_d = 1'b0; // [R2]
            hold_d = 1'b0; // [R2]
        end
        else
        begin
            count_d = capture_q ? count_q + 8'h0001 : count_q; // [R8]
            setup_d = setup_q || setup_err;
            hold_d = hold_q || hold_err;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            left_q <= RST_IGNORE_COUNT;
            done_q <= 1'b0;
            capture_q <= 1'b0;
            count_q <= RST_CAPTURE_COUNT;
            setup_q <= 1'b0;
            hold_q <= 1'b0;
        end
        else
        begin
            left_q <= left_d;
            done_q <= done_d;
            capture_q <= capture_d;
            count_q <= count_d;
            setup_q <= setup_d;
            hold_q <= hold_d;
        end
    end

    scs_delay_line #(
        .DEPTH(TIMESTAMP_DEPTH),
        .SEL_W(7)
    ) i_scs_delay_line (
        .core_clk(core_clk),
        .rst(rst),
        .evt(capture_q),
        .delay(delay_q),
        .pulse_q(sysref_timestamp)
    );

    assign reg_rdata = rdata_q;
    assign stabilizer2_enable = stabilizer2_q[STABILIZER_ENABLE_BIT]; // [R1]
    assign stabilizer2_power = stabilizer2_q[STABILIZER_POWER_BIT]; // [R1]
    assign stabilizer3_ctrl = stabilizer3_q;
    assign sysref_capture = capture_q;
    assign setup_flag = setup_q;
    assign hold_flag = hold_q;
    assign sysref_count = count_q;

    a_flags_held: assert property ( // [R2]
        @(posedge core_clk) disable iff (rst)
        ctrl_q[FLAG_RESET_BIT] |=> (!setup_q && !hold_q))
        else $error("error flags not cleared under flag reset");

    a_count_clear: assert property ( // [R8]
        @(posedge core_clk) disable iff (rst)
        ctrl_q[FLAG_RESET_BIT] ##1 ctrl_q[FLAG_RESET_BIT] |-> count_q == 8'h0000)
        else $error("capture count not cleared");

    a_count_step: assert property ( // [R8]
        @(posedge core_clk) disable iff (rst)
        (capture_q && !ctrl_q[FLAG_RESET_BIT]) |=> count_q == $past(count_q) + 8'h0001)
        else $error("capture count did not advance by one");

    a_disabled_quiet: assert property ( // [R4]
        @(posedge core_clk) disable iff (rst)
        (mode == MODE_DISABLED) |=> !capture_q)
        else $error("capture while disabled");

    a_cont_capture: assert property ( // [R4]
        @(posedge core_clk) disable iff (rst)
        (mode == MODE_CONTINUOUS && valid_trans) |=> capture_q)
        else $error("continuous mode missed a transition");

    a_trans_polarity: assert property ( // [R3]
        @(posedge core_clk) disable iff (rst)
        capture_q |-> ($past(ctrl_q[TRANS_SELECT_BIT]) ? ($past(prev_q) && !prev_q)
                                                       : (!$past(prev_q) && prev_q)))
        else $error("capture on the wrong transition");

    a_nshot_single: assert property ( // [R9]
        @(posedge core_clk) disable iff (rst)
        (mode == MODE_NSHOT && done_q && !ctrl_wr) |=> !capture_q)
        else $error("second capture in n-shot mode");

    a_ignore_skip: assert property ( // [R6]
        @(posedge core_clk) disable iff (rst)
        (mode == MODE_NSHOT && !done_q && valid_trans && left_q != 4'h0 && !ctrl_wr)
        |=> (!capture_q && left_q == $past(left_q) - 4'h1))
        else $error("ignored transition not skipped");

    a_stamp_zero: assert property ( // [R7]
        @(posedge core_clk) disable iff (rst)
        (capture_q && delay_q == 7'h00) |=> sysref_timestamp)
        else $error("zero delay timestamp late");

    a_delay_reset: assert property ( // [R7]
        @(posedge core_clk) disable iff (rst)
        $past(rst) |-> delay_q == RST_TIMESTAMP_DELAY)
        else $error("timestamp delay reset value wrong");
endmodule

// ---- verification/scs_sysref_gen.sv ----
`timescale 1ns/1ps
module scs_sysref_gen
(
    input wire logic core_clk,
    input wire logic start,
    input wire logic [4:0] count,
    output logic sysref_pin,
    output logic busy
);
    int left = 0;
    int ph = 0;
    initial sysref_pin = 1'b0;
    // four cycles high, four low; edges land off the sampling edge
    always @(posedge core_clk)
    begin
        if (start && left == 0)
        begin
            left = count;
            ph = 0;
        end
        else if (left != 0)
        begin
            ph = ph + 1;
            if (ph == 8)
            begin
                ph = 0;
                left = left - 1;
            end
        end
        sysref_pin <= #3 (left != 0 && ph < 4);
    end
    assign busy = (left != 0);
endmodule

// ---- verification/sysref_capture_control_test.sv ----
`timescale 1ns/1ps
module sysref_capture_control_test;
    import scs_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic setup_err = 1'b0;
    logic hold_err = 1'b0;
    logic start = 1'b0;
    logic [4:0] npulse = '0;
    logic [7:0] reg_rdata, stabilizer3_ctrl, sysref_count;
    logic sysref_pin, busy, stabilizer2_enable, stabilizer2_power;
    logic sysref_capture, sysref_timestamp, setup_flag, hold_flag;
    logic pin_q = 1'b0;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0, caps = 0, rises = 0, cap_at = 0, ts_at = 0, rise_at = 0, fall_at = 0, rises_cap = 0;
    always #10 core_clk = ~core_clk;
    scs_capture i_scs_capture (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
        .sysref_pin, .setup_err, .hold_err, .stabilizer2_enable, .stabilizer2_power,
        .stabilizer3_ctrl, .sysref_capture,
        .sysref_timestamp, .setup_flag, .hold_flag, .sysref_count);
    scs_sysref_gen i_scs_sysref_gen (.core_clk, .start, .count(npulse), .sysref_pin, .busy);
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        pin_q <= sysref_pin;
        rises <= rises + int'(sysref_pin && !pin_q);
        if (sysref_pin && !pin_q)
            rise_at <= cyc;
        if (!sysref_pin && pin_q)
            fall_at <= cyc;
        if (sysref_capture === 1'b1)
        begin
            caps <= caps + 1;
            cap_at <= cyc;
            rises_cap <= rises;
        end
        if (sysref_timestamp === 1'b1)
            ts_at <= cyc;
    end
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge core_clk);
        reg_we <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge core_clk);
        reg_re <= 1'b0;
        @(posedge core_clk);
        #1;
        chk($sformatf("reg %h", a), e, reg_rdata);
    endtask
    task automatic pulses(input int n);
        @(posedge core_clk);
        npulse <= 5'(n);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        repeat (300)
        begin
            @(posedge core_clk);
            #1;
            if (!busy)
            begin
                repeat (8) @(posedge core_clk);
                #1;
                return;
            end
        end
        errors++;
        $display("[FAIL] partner idle expected 1 seen 0");
        give_verdict();
    endtask
    task automatic err(input logic s, input logic h);
        @(posedge core_clk);
        setup_err <= s;
        hold_err <= h;
        @(posedge core_clk);
        setup_err <= 1'b0;
        hold_err <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic t_reset();
        logic [11:0] a[6] = '{12'h011e, 12'h011f, 12'h0120, 12'h0121, 12'h0123, 12'h0122};
        logic [7:0] e[6] = '{8'h88, 8'h84, 8'h00, 8'h00, 8'h40, 8'h00};
        foreach (a[i])
            rchk(a[i], e[i]);
        chk("stabilizer3_ctrl", 8'h84, stabilizer3_ctrl);
        $display("test reset done");
    endtask
    task automatic t_dcs();
        wr(12'h011e, 8'h89);
        chk("stabilizer2 power", 8'h01, {stabilizer2_enable, stabilizer2_power});
        wr(12'h011e, 8'h8b);
        chk("stabilizer2 enable", 8'h03, {stabilizer2_enable, stabilizer2_power});
        wr(12'h011f, 8'h81);
        chk("stabilizer3_ctrl", 8'h81, stabilizer3_ctrl);
        $display("test stabilizer done");
    endtask
    task automatic t_modes();
        logic [7:0] v[4] = '{8'h02, 8'h12, 8'h0a, 8'h1a};
        int c;
        c = caps;
        pulses(1);
        chk("captures off", 8'(c), 8'(caps));
        foreach (v[i])
        begin
            wr(12'h0120, 8'h00);
            wr(12'h0120, v[i] & 8'h18);
            wr(12'h0120, v[i]);
            rchk(12'h0120, v[i]);
            c = caps;
            pulses(1);
            chk("captures", 8'(c + 1), 8'(caps));
            chk("capture lag", 8'h01, 8'((cap_at - (v[i][4] ? fall_at : rise_at)) inside {[2:6]}));
        end
        repeat (70) @(posedge core_clk);
        chk("timestamp lag", 8'h41, 8'(ts_at - cap_at));
        $display("test modes done");
    endtask
    task automatic t_nshot();
        logic [3:0] n[3] = '{4'h0, 4'h3, 4'hf};
        int c, r;
        foreach (n[i])
        begin
            wr(12'h0120, 8'h00);
            wr(12'h0121, {4'hf, n[i]});
            rchk(12'h0121, {4'h0, n[i]});
            wr(12'h0120, 8'h04);
            c = caps;
            r = rises;
            pulses(int'(n[i]) + 3);
            chk("n-shot captures", 8'(c + 1), 8'(caps));
            chk("n-shot pick", 8'(n[i] + 1), 8'(rises_cap - r));
        end
        $display("test n-shot done");
    endtask
    task automatic t_count();
        int c;
        wr(12'h0120, 8'h00);
        wr(12'h0123, 8'hff);
        rchk(12'h0123, 8'h7f);
        wr(12'h0120, 8'h42);
        pulses(2);
        chk("count held", 8'h00, sysref_count);
        wr(12'h0120, 8'h02);
        c = caps;
        repeat (9) pulses(31);
        chk("wrap captures", 8'(279), 8'(caps - c));
        chk("count wrap", 8'(279), sysref_count);
        wr(12'h0120, 8'h00);
        rchk(12'h012a, 8'(279));
        repeat (130) @(posedge core_clk);
        chk("timestamp lag", 8'h80, 8'(ts_at - cap_at));
        wr(12'h0123, 8'h00);
        wr(12'h0120, 8'h02);
        pulses(1);
        chk("zero delay lag", 8'h01, 8'(ts_at - cap_at));
        wr(12'h0120, 8'h00);
        $display("test count done");
    endtask
    task automatic t_flags();
        err(1'b1, 1'b0);
        chk("flags", 8'h02, {setup_flag, hold_flag});
        err(1'b0, 1'b1);
        chk("flags", 8'h03, {setup_flag, hold_flag});
        wr(12'h0120, 8'h40);
        err(1'b1, 1'b1);
        chk("flags held", 8'h00, {setup_flag, hold_flag});
        wr(12'h0120, 8'h00);
        chk("flags released", 8'h00, {setup_flag, hold_flag});
        err(1'b1, 1'b0);
        chk("flags resumed", 8'h02, {setup_flag, hold_flag});
        $display("test flags done");
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_dcs();
        t_modes();
        t_nshot();
        t_count();
        t_flags();
        give_verdict();
    end
endmodule
